// >>> verilog/psx_consts.vh
// Constants for the pulse input scaling extension block
`ifndef PSX_CONSTS_VH
`define PSX_CONSTS_VH
`define PSX_CMD_WR_LATCH_CFG 8'hA0
`define PSX_CMD_WR_SCALE_CFG 8'hA1
`define PSX_CMD_WR_ENV_TWO 8'h9D
`define PSX_CMD_RD_LATCH_CFG 8'hE0
`define PSX_CMD_RD_SCALE_CFG 8'hE1
`define PSX_CMD_RD_ENV_TWO 8'hDD
`define PSX_CMD_RD_STATUS 8'hF1
`define PSX_CMD_RD_ARC 8'hFD
`define PSX_CMD_RD_CNT_BASE 8'hE4
`define PSX_CMD_STOP 8'h49
`define PSX_CMD_RESID_LO 8'h54
`define PSX_CMD_RESID_HI 8'h57
`define PSX_CMD_PRESET 8'h4F
`define PSX_LCLR_LSB 24
`define PSX_FEED_BIT 15
`define PSX_DIV_LSB 16
`define PSX_DIV_MSB 26
`define PSX_MUL_LSB 27
`define PSX_MUL_MSB 31
`define PSX_DISABLE_BIT 31
`define PSX_CMP5_LVL_LSB 18
`define PSX_OP_LVL_LSB 20
`define PSX_DIV_FULL 12'h800
`define PSX_RESET_WORD 32'h00000000
`endif

// >>> verilog/psx_pulse_scale.v
// Pulse input scaling, latch-clear counters, status and arc resume logic
//
// Behaviour
// - Each counter with latch-clear enabled is cleared when its value is latched.
// - With feed-through set, a burst already in flight keeps flowing after stop; new input pulses are not taken.
// - Input rate is divided by eleven-bit setting over 2048, bits 16 to 26.
// - Input rate is multiplied by five-bit field plus one, bits 27 to 31.
// - Status bits 18 to 19 show compare-five pre-register queue level.
// - Status bits 20 to 21 show operation pre-register queue level.
// - Read-only arc step count register; bit 31 always reads zero.
// - Residual start commands 54h to 57h resume a stopped arc.
// - Pair disable bit 31 of env config two ignores external pulse pair.
`include "psx_consts.vh"
`timescale 1ns/1ns
`default_nettype none
module psx_pulse_scale #(
  parameter MUL_W = 5,
  parameter DIV_W = 11
) (
  input wire clk,
  input wire rst,
  input wire buf_wr,
  input wire [31:0] buf_wdata,
  input wire cmd_wr,
  input wire [7:0] cmd_code,
  output reg [31:0] buf_rdata,
  input wire pair_pulse,
  input wire [3:0] count_event,
  input wire [3:0] latch_event,
  input wire arc_step,
  input wire arc_done,
  input wire [1:0] cmp_five_queue_level,
  input wire [1:0] op_queue_level,
  input wire [15:0] status_low,
  input wire [1:0] status_misc,
  output wire out_valid,
  input wire out_ready,
  output wire out_pulse,
  output reg arc_resume,
  output reg arc_active
);
  reg [31:0] buf_r;
  reg [31:0] latch_sync_config_r;
  reg [31:0] pulse_input_scale_config_r;
  reg [31:0] env_config_two_r;
  reg [30:0] arc_cnt_r;
  reg arc_stopped_r;
  reg [31:0] cnt_r [0:3];
  reg [31:0] latch_r [0:3];
  reg [11:0] acc_r;
  reg [5:0] mul_left_r;
  reg pend_r;
  reg stopping_r;
  reg [1:0] fifo_cnt_r;
  wire [DIV_W-1:0] input_divide_setting;
  wire [MUL_W-1:0] input_multiply_setting;
  wire stop_feed_through;
  wire pulse_pair_disable;
  wire cmd_stop;
  wire in_ok;
  wire fifo_in_ready;
  wire gen_pulse;
  wire [12:0] acc_sum;
  wire [31:0] extended_status;
  // Command decode and named fields
  wire cmd_preset;
  wire cmd_resid;
  wire stop_blocked;
  wire acc_carry;
  wire latch_clear_en_one;
  wire latch_clear_en_two;
  wire latch_clear_en_three;
  wire latch_clear_en_four;
  wire [3:0] latch_clear_en;
  wire [31:0] arc_step_count;
  // Buffer occupancy next value
  reg [1:0] fifo_cnt_nxt;

  assign input_divide_setting = pulse_input_scale_config_r[`PSX_DIV_MSB:`PSX_DIV_LSB];
  assign input_multiply_setting = pulse_input_scale_config_r[`PSX_MUL_MSB:`PSX_MUL_LSB];
  assign stop_feed_through = pulse_input_scale_config_r[`PSX_FEED_BIT];
  assign pulse_pair_disable = env_config_two_r[`PSX_DISABLE_BIT];
  assign cmd_stop = cmd_wr && (cmd_code == `PSX_CMD_STOP);

  // Operation command decode; resume codes form one contiguous range
  assign cmd_preset = cmd_wr && (cmd_code == `PSX_CMD_PRESET);
  assign cmd_resid = cmd_wr && (cmd_code >= `PSX_CMD_RESID_LO) && (cmd_code <= `PSX_CMD_RESID_HI);
  // Stop takes hold in the very cycle the command lands
  assign stop_blocked = stopping_r || cmd_stop;

  // Latch-clear enables, one per counter
  assign latch_clear_en_one = latch_sync_config_r[`PSX_LCLR_LSB];
  assign latch_clear_en_two = latch_sync_config_r[`PSX_LCLR_LSB + 1];
  assign latch_clear_en_three = latch_sync_config_r[`PSX_LCLR_LSB + 2];
  assign latch_clear_en_four = latch_sync_config_r[`PSX_LCLR_LSB + 3];
  assign latch_clear_en = {latch_clear_en_four, latch_clear_en_three, latch_clear_en_two, latch_clear_en_one};

  // Read-only arc step word; top bit is wired to zero
  assign arc_step_count = {1'b0, arc_cnt_r};

  // Host buffer and register write commands
  // Words reach a register only through the buffer
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      buf_r <= `PSX_RESET_WORD;
      latch_sync_config_r <= `PSX_RESET_WORD;
      pulse_input_scale_config_r <= `PSX_RESET_WORD;
      env_config_two_r <= `PSX_RESET_WORD;
    end else begin
      // Buffer load
      if (buf_wr) begin
        buf_r <= buf_wdata;
      end
      if (cmd_wr) begin
        case (cmd_code)
          `PSX_CMD_WR_LATCH_CFG: begin
            latch_sync_config_r <= buf_r;
          end
          `PSX_CMD_WR_SCALE_CFG: begin
            pulse_input_scale_config_r <= buf_r;
          end
          `PSX_CMD_WR_ENV_TWO: begin
            env_config_two_r <= buf_r;
          end
          default: ;
        endcase
      end
    end
  end

  // Status word assembly
  // Reserved top bits read as zero
  assign extended_status = {10'h000, op_queue_level, cmp_five_queue_level,
                            status_misc, status_low};

  // Read commands load the read-back word
  // A buffer write also shows through, so the host sees what it loaded
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      buf_rdata <= `PSX_RESET_WORD;
    end else if (buf_wr) begin
      buf_rdata <= buf_wdata;
    end else if (cmd_wr) begin
      // Unknown codes leave the word as it stands
      case (cmd_code)
        `PSX_CMD_RD_LATCH_CFG: begin
          buf_rdata <= latch_sync_config_r;
        end
        `PSX_CMD_RD_SCALE_CFG: begin
          buf_rdata <= pulse_input_scale_config_r;
        end
        `PSX_CMD_RD_ENV_TWO: begin
          buf_rdata <= env_config_two_r;
        end
        `PSX_CMD_RD_STATUS: begin
          buf_rdata <= extended_status;
        end
        `PSX_CMD_RD_ARC: begin
          buf_rdata <= arc_step_count;
        end
        `PSX_CMD_RD_CNT_BASE: begin
          buf_rdata <= latch_r[0];
        end
        `PSX_CMD_RD_CNT_BASE + 8'h01: begin
          buf_rdata <= latch_r[1];
        end
        `PSX_CMD_RD_CNT_BASE + 8'h02: begin
          buf_rdata <= latch_r[2];
        end
        `PSX_CMD_RD_CNT_BASE + 8'h03: begin
          buf_rdata <= latch_r[3];
        end
        default: buf_rdata <= buf_rdata;
      endcase
    end
  end

  // Four counters with latch and optional clear
  genvar gi;
  generate
    // One counter and latch per entry, in read command order
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_cnt
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          cnt_r[gi] <= `PSX_RESET_WORD;
          latch_r[gi] <= `PSX_RESET_WORD;
        end else begin
          if (latch_event[gi]) begin
            latch_r[gi] <= cnt_r[gi];
          end
          // Clear beats a count in the same cycle; that count is dropped
          if (latch_event[gi] && latch_clear_en[gi]) begin
            cnt_r[gi] <= `PSX_RESET_WORD;
          end else if (count_event[gi]) begin
            cnt_r[gi] <= cnt_r[gi] + 32'h00000001;
          end
        end
      end
    end
  endgenerate

  // Input pulse accepted unless disabled or stopped, whatever the feed-through bit
  // Disable wins over everything on the pair input
  assign in_ok = pair_pulse && !pulse_pair_disable;

  // Fractional divider: accumulate setting, carry at 2048
  // The remainder is kept, so the long-run rate is exact
  assign acc_sum = {2'b00, acc_r[10:0]} + {2'b00, input_divide_setting};
  assign acc_carry = (acc_sum >= {1'b0, `PSX_DIV_FULL});

  // Multiplier burst: each divided pulse yields setting plus one outputs
  // Push only when the buffer has room
  assign gen_pulse = (mul_left_r != 6'h00) && fifo_in_ready;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_r <= 12'h000;
      mul_left_r <= 6'h00;
      pend_r <= 1'b0;
      stopping_r <= 1'b0;
    end else begin
      // Stop state holds until the preset command
      if (cmd_stop) begin
        stopping_r <= 1'b1;
      end else if (cmd_preset) begin
        stopping_r <= 1'b0;
      end
      if (in_ok && !stop_blocked) begin
        acc_r <= {1'b0, acc_sum[10:0]};
        if (acc_carry) begin
          pend_r <= 1'b1;
        end
      end
      // Without feed-through a stop drops the burst in flight
      if (stop_blocked && !stop_feed_through) begin
        mul_left_r <= 6'h00;
        pend_r <= 1'b0;
      end else if (mul_left_r == 6'h00 && pend_r) begin
        mul_left_r <= {1'b0, input_multiply_setting} + 6'h01;
        pend_r <= 1'b0;
      end else if (gen_pulse) begin
        mul_left_r <= mul_left_r - 6'h01;
      end
    end
  end

  // Two-entry output buffer
  // A stalled receiver backs up into the burst counter; only one further divided pulse can wait in pend_r
  assign fifo_in_ready = (fifo_cnt_r != 2'b10);
  assign out_valid = (fifo_cnt_r != 2'b00);
  assign out_pulse = out_valid && out_ready;

  // Occupancy next value: push, pop, or both at once
  always @* begin
    fifo_cnt_nxt = fifo_cnt_r;
    case ({gen_pulse, out_pulse})
      2'b10: fifo_cnt_nxt = fifo_cnt_r + 2'b01;
      2'b01: fifo_cnt_nxt = fifo_cnt_r - 2'b01;
      default: fifo_cnt_nxt = fifo_cnt_r;
    endcase
  end

  // Occupancy register
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      fifo_cnt_r <= 2'b00;
    end else begin
      fifo_cnt_r <= fifo_cnt_nxt;
    end
  end

  // Arc step counter with stop and residual resume
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      arc_cnt_r <= 31'h00000000;
      arc_stopped_r <= 1'b0;
      arc_active <= 1'b0;
      arc_resume <= 1'b0;
    end else begin
      arc_resume <= 1'b0;
      // Resume only acts when an arc was cut short
      if (cmd_resid && arc_stopped_r) begin
        arc_resume <= 1'b1;
        arc_active <= 1'b1;
        arc_stopped_r <= 1'b0;
      // Stop only marks an arc that is running
      end else if (cmd_stop && arc_active) begin
        arc_active <= 1'b0;
        arc_stopped_r <= 1'b1;
      end else if (arc_done) begin
        // Normal completion clears the count for the next arc
        arc_active <= 1'b0;
        arc_stopped_r <= 1'b0;
        arc_cnt_r <= 31'h00000000;
      end else if (arc_step) begin
        arc_active <= 1'b1;
        arc_cnt_r <= arc_cnt_r + 31'h00000001;
      end
    end
  end
endmodule
`default_nettype wire

// >>> testbench/psx_checker_assertions.sv
// Port checker for the scaling block
`timescale 1ns/1ns
`default_nettype none
module psx_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic buf_wr,
  input wire logic cmd_wr,
  input wire logic [7:0] cmd_code,
  input wire logic [31:0] buf_rdata,
  input wire logic [1:0] cmp_five_queue_level,
  input wire logic [1:0] op_queue_level,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic out_pulse,
  input wire logic arc_resume
);
  logic res_r;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Resume command taken at the last edge
  always @(posedge clk or posedge rst)
    if (rst)
      res_r <= 1'b0;
    else
      res_r <= cmd_wr && cmd_code[7:2] == 6'h15;
  a_resume_once: assert property (arc_resume |=> !arc_resume) else $error("res twice");
  a_stall_hold: assert property (out_valid && !out_ready && !cmd_wr |=> out_valid) else $error("lost");
  a_rdata_hold: assert property (!cmd_wr && !buf_wr |=> $stable(buf_rdata)) else $error("buf");
  a_cmp5_level: assert property (cmd_wr && cmd_code == 8'hF1 |=>
    buf_rdata[19:18] == $past(cmp_five_queue_level)) else $error("c5");
  a_op_level: assert property (cmd_wr && cmd_code == 8'hF1 |=>
    buf_rdata[21:20] == $past(op_queue_level)) else $error("op");
  a_status_top: assert property (cmd_wr && cmd_code == 8'hF1 |=> buf_rdata[31:22] == 10'h000) else $error("st");
  a_arc_msb: assert property (cmd_wr && cmd_code == 8'hFD |=> !buf_rdata[31]) else $error("msb");
  a_resume_cause: assert property (arc_resume |-> res_r) else $error("res");
  c_read: cover property (cmd_wr && cmd_code == 8'hE1);
  c_stall: cover property (out_valid && !out_ready);
  c_resume: cover property (res_r);
endmodule
bind psx_pulse_scale psx_checker chk (.clk(clk), .rst(rst), .buf_wr(buf_wr), .cmd_wr(cmd_wr),
  .cmd_code(cmd_code), .buf_rdata(buf_rdata), .cmp_five_queue_level(cmp_five_queue_level),
  .op_queue_level(op_queue_level), .out_valid(out_valid), .out_ready(out_ready),
  .out_pulse(out_pulse), .arc_resume(arc_resume));
`default_nettype wire

// >>> testbench/psx_sink.sv
// Receiver model: random stalls, counts pulses
`timescale 1ns/1ns
`default_nettype none
module psx_sink (
  input wire logic clk,
  input wire logic rst,
  input wire logic stall,
  input wire logic out_pulse,
  output logic out_ready,
  output logic [31:0] count
);
  logic [7:0] rnd_r;
  // Ready drops at random while stalling
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rnd_r <= 8'hA5;
      out_ready <= 1'b0;
      count <= 32'h0;
    end else begin
      rnd_r <= {rnd_r[6:0], rnd_r[7] ^ rnd_r[5]};
      out_ready <= !(stall && rnd_r[0]);
      count <= count + {31'h0, out_pulse};
    end
  end
endmodule
`default_nettype wire

// >>> testbench/tb.sv
// Self-checking bench for the scaling block
`timescale 1ns/1ns
`default_nettype none
`include "psx_consts.vh"
module tb;
  reg clk = 0, rst = 1, bw = 0, cw = 0, pp = 0, as = 0, stl = 0, chk = 0;
  reg [31:0] wd = 0, sd = 32'h10B8E892;
  reg [7:0] cc = 0;
  reg [3:0] ce = 0, le = 0;
  reg [21:0] st = 0;
  wire [31:0] rdw, sc;
  wire ov, ordy, op, ar, aa;
  integer miscompares = 0, n_tests = 0, i, j, nres = 0;
  reg [31:0] q[$];
  psx_pulse_scale dut (.clk(clk), .rst(rst), .buf_wr(bw), .buf_wdata(wd), .cmd_wr(cw), .cmd_code(cc),
    .buf_rdata(rdw), .pair_pulse(pp), .count_event(ce), .latch_event(le), .arc_step(as), .arc_done(1'b0),
    .cmp_five_queue_level(st[19:18]), .op_queue_level(st[21:20]), .status_low(st[15:0]),
    .status_misc(st[17:16]), .out_valid(ov), .out_ready(ordy), .out_pulse(op), .arc_resume(ar), .arc_active(aa));
  psx_sink snk (.clk(clk), .rst(rst), .stall(stl), .out_pulse(op), .out_ready(ordy), .count(sc));
  initial forever #25 clk = ~clk;
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Resume pulses seen
  always @(posedge clk) if (ar) nres <= nres + 1;
  task cmp(input [31:0] a, input [31:0] b);
    n_tests = n_tests + 1;
    if (a !== b) begin
      miscompares = miscompares + 1;
      $display("[ERR] %0t got %h exp %h", $time, a, b);
    end
  endtask
  task report_and_stop;
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task cmd(input [7:0] c);
    cw <= 1;
    cc <= c;
    @(posedge clk);
    cw <= 0;
    @(posedge clk);
  endtask
  task wr(input [7:0] c, input [31:0] d);
    bw <= 1;
    wd <= d;
    @(posedge clk);
    bw <= 0;
    cmd(c);
  endtask
  task rd(input [7:0] c, input [31:0] e);
    q.push_back(e);
    cmd(c);
  endtask
  task pls(input integer n);
    repeat (n) begin
      pp <= 1;
      @(posedge clk);
      pp <= 0;
      repeat (7) @(posedge clk);
    end
  endtask
  task ev(input integer k);
    repeat (k) begin
      ce <= 4'h1 << j;
      @(posedge clk);
      ce <= 4'h0;
      @(posedge clk);
    end
    le <= 4'h1 << j;
    @(posedge clk);
    le <= 4'h0;
    @(posedge clk);
  endtask
  task waitc(input [31:0] n);
    for (i = 0; i < 400 && sc !== n; i = i + 1) @(posedge clk);
    cmp(sc, n);
    if (i == 400) report_and_stop;
    $display("test ends at %0t", $time);
  endtask
  // Read results are checked one cycle after the command
  always @(posedge clk) begin
    if (chk) cmp(rdw, q.pop_front());
    chk <= cw && cc[7:6] == 2'b11;
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    sd = lfsr(sd);
    st <= sd[21:0];
    wr(`PSX_CMD_WR_SCALE_CFG, sd);
    rd(`PSX_CMD_RD_SCALE_CFG, sd);
    repeat (5) begin
      as <= 1;
      @(posedge clk);
      as <= 0;
      @(posedge clk);
    end
    rd(`PSX_CMD_RD_STATUS, {10'h000, sd[21:0]});
    rd(`PSX_CMD_RD_ARC, 32'h5);
    wr(`PSX_CMD_WR_LATCH_CFG, 32'h0F000000);
    for (j = 0; j < 4; j = j + 1) begin
      ev(j + 2);
      rd(`PSX_CMD_RD_CNT_BASE + j, j + 2);
      ev(1);
      rd(`PSX_CMD_RD_CNT_BASE + j, 1);
    end
    // Times two, divide by half, receiver stalling
    wr(`PSX_CMD_WR_SCALE_CFG, 32'h0C008000);
    stl <= 1;
    pls(8);
    waitc(8);
    wr(`PSX_CMD_WR_ENV_TWO, 32'h80000000);
    pls(4);
    wr(`PSX_CMD_WR_ENV_TWO, 0);
    waitc(8);
    // Burst of eight must finish across a stop
    wr(`PSX_CMD_WR_SCALE_CFG, 32'h3FFF8000);
    pls(2);
    cmd(`PSX_CMD_STOP);
    waitc(16);
    for (j = `PSX_CMD_RESID_LO; j <= `PSX_CMD_RESID_HI; j = j + 1) cmd(j);
    cmp(nres, 1);
    cmp(aa, 1);
    $display("resume test ends at %0t", $time);
    cmd(`PSX_CMD_PRESET);
    report_and_stop;
  end
endmodule
`default_nettype wire
